//--- logic/scs_defs.svh
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

// ----------------------------------------------------------------------------
// register indices; the wishbone byte address is four times the index
// ----------------------------------------------------------------------------
`define SCS_ADDR_W 18
`define SCS_CTRL_IDX 16'hFFDA
`define SCS_STAT_IDX 16'hFFDC
`define SCS_CFG_IDX 16'hFFE0
`define SCS_IRQ_STAT_IDX 16'hFFE1
`define SCS_IRQ_MASK_IDX 16'hFFE2

// ----------------------------------------------------------------------------
// reset values and fixed bits
// ----------------------------------------------------------------------------
`define SCS_CTRL_RST 8'h0C
`define SCS_STAT_RST 8'h87
`define SCS_CTRL_RSVD 8'h0C
`define SCS_STAT_RSVD 8'h07
`define SCS_CFG_RST 8'h00
`define SCS_IRQ_RST 3'h0

// ----------------------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------------------
`define SCS_TIE_BIT 7
`define SCS_RIE_BIT 6
`define SCS_TE_BIT 5
`define SCS_RE_BIT 4
`define SCS_EXTERNAL_CLOCK_SELECT_BIT 1
`define SCS_CLOCK_OUTPUT_ENABLE_BIT 0

// ----------------------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------------------
`define SCS_TX_BUFFER_EMPTY_FLAG_BIT 7
`define SCS_RX_BUFFER_FULL_FLAG_BIT 6
`define SCS_OVERRUN_FLAG_BIT 5
`define SCS_FER_BIT 4
`define SCS_PER_BIT 3

// ----------------------------------------------------------------------------
// config and interrupt field positions
// ----------------------------------------------------------------------------
`define SCS_CFG_SYNC_BIT 0
`define SCS_CFG_PAR_BIT 1
`define SCS_IRQ_W 3
`define SCS_IRQ_TX_BIT 0
`define SCS_IRQ_RX_BIT 1
`define SCS_IRQ_ERR_BIT 2

`endif

//--- logic/scs_pkg.sv
package scs_pkg;
  // ----------------------------------------------------------------------------
  // bus handshake states, gray coded along idle -> ack -> idle
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SCS_BUS_IDLE = 2'h0,
    SCS_BUS_ACK = 2'h1
  } scs_bus_state_t;

  typedef logic [7:0] scs_byte_t; // one register byte
endpackage

//--- logic/scs_sync.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// two flip-flop synchroniser for a group of independent levels
// ----------------------------------------------------------------------------
module scs_sync #(
  parameter int W = 2
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  scs_sync_if.sync_side port
);
  // only independent levels may pass; a bus value could tear across bits
  if (W < 1) begin : g_check
    $error("scs_sync needs at least one bit");
  end

  logic [W-1:0] stage1; // metastable stage, read only by stage2
  logic [W-1:0] stage2; // settled copy

  // both stages reset low so nothing reads an unknown level
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= port.async_bits;
      stage2 <= stage1;
    end
  end

  assign port.sync_bits = stage2;
endmodule

//--- logic/scs_sync_if.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// carries raw pin levels to the synchroniser and the clean copies back
// ----------------------------------------------------------------------------
interface scs_sync_if #(
  parameter int W = 2
);
  logic [W-1:0] async_bits; // raw levels from outside the clock domain
  logic [W-1:0] sync_bits;  // levels after two flip-flops
  modport sync_side(input async_bits, output sync_bits);
  modport user_side(output async_bits, input sync_bits);
endinterface

//--- logic/scs_top.sv
`timescale 1ns/1ps
`include "scs_defs.svh"
// Notes on behaviour
// - control register reloads 0x0C on reset/standby
// - bit 7 gates transmit-empty request
// - bit 6 gates receive-full and error requests
// - bit 5 enables transmitter, owns transmit pin
// - bit 4 enables receiver, owns receive pin
// - control bits 3,2 read one, unwritable
// - bit 1 selects external clock, pin input
// - bit 0 drives clock out, sync internal
// - status register reloads 0x87 on reset/standby
// - software clears flags only by writing zero
// - transmit-empty clears: read-then-zero or controller write
// - transmit-empty sets: reset, shifter load, disable
// - receive-full sets on clean character completion
// - receive-full clears: read-zero, controller read, reset
// - overrun sets when character completes while full
// - overrun clears: read-then-zero or reset
// - framing error on zero stop bit
// - parity error in async mode with parity
module scs_top (
  input wire logic clock_in,
  input wire logic rst_n_in,
  // classic wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [`SCS_ADDR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // chip events
  input wire logic standby_in,
  input wire logic tx_load_in,
  input wire logic ctrl_tx_write_in,
  input wire logic ctrl_rx_read_in,
  input wire logic rx_done_in,
  input wire logic rx_stop_bit_in,
  input wire logic rx_parity_bad_in,
  input wire logic tx_serial_in,
  input wire logic int_sck_in,
  // link pins
  input wire logic rxd_in,
  output logic txd_out,
  output logic txd_oe_out,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_out,
  // towards shifters and interrupt controller
  output logic rx_data_out,
  output logic ext_clk_rise_out,
  output logic tx_empty_request_out,
  output logic rx_full_request_out,
  output logic rx_error_request_out,
  output logic irq_out
);
  import scs_pkg::*;

  // ----------------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------------
  logic rst_q1; // first release stage
  logic rst_n;  // released reset used by all logic

  // assert at once, release after two edges so no flop leaves reset mid-cycle
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  scs_sync_if #(.W(2)) pins_if ();
  logic sck_sync; // clean serial clock level
  logic rxd_sync; // clean receive level
  logic sck_prev; // serial clock one cycle ago

  assign pins_if.async_bits = {sck_in, rxd_in};
  assign sck_sync = pins_if.sync_bits[1];
  assign rxd_sync = pins_if.sync_bits[0];

  scs_sync #(.W(2)) u_sync (
    .clk_in(clock_in),
    .rst_n_in(rst_n),
    .port(pins_if.sync_side)
  );

  // ----------------------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------------------
  scs_bus_state_t bus_state; // idle or answering
  logic bus_req;     // master asking, not yet answered
  logic bus_go;      // access completes at this edge
  logic wr_go;       // write completes at this edge
  logic rd_go;       // read completes at this edge
  logic lane0;       // low byte lane selected
  logic hit_ctrl;    // control register addressed
  logic hit_stat;    // status register addressed
  logic hit_cfg;     // config register addressed
  logic hit_istat;   // interrupt status addressed
  logic hit_imask;   // interrupt mask addressed
  logic [7:0] wbyte; // written byte

  assign bus_req = wb_cyc_in && wb_stb_in && (bus_state == SCS_BUS_IDLE);
  assign bus_go = wb_cyc_in && wb_stb_in && (bus_state == SCS_BUS_ACK);
  assign wr_go = bus_go && wb_we_in && lane0;
  assign rd_go = bus_go && !wb_we_in;
  assign lane0 = wb_sel_in[0];
  assign wbyte = wb_dat_in[7:0];
  assign hit_ctrl = (wb_adr_in == {`SCS_CTRL_IDX, 2'h0});
  assign hit_stat = (wb_adr_in == {`SCS_STAT_IDX, 2'h0});
  assign hit_cfg = (wb_adr_in == {`SCS_CFG_IDX, 2'h0});
  assign hit_istat = (wb_adr_in == {`SCS_IRQ_STAT_IDX, 2'h0});
  assign hit_imask = (wb_adr_in == {`SCS_IRQ_MASK_IDX, 2'h0});

  // one wait state: data is registered, ack follows one cycle later
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= SCS_BUS_IDLE;
    end else begin
      case (bus_state)
        SCS_BUS_IDLE: begin
          if (bus_req) begin
            bus_state <= SCS_BUS_ACK;
          end
        end
        SCS_BUS_ACK: begin
          bus_state <= SCS_BUS_IDLE; // ack lasts exactly one cycle
        end
        default: begin
          bus_state <= SCS_BUS_IDLE;
        end
      endcase
    end
  end

  assign wb_ack_out = (bus_state == SCS_BUS_ACK);

  // ----------------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------------
  scs_byte_t ctrl;  // control register
  scs_byte_t cfg;   // mode: sync and parity enable
  logic tx_empty_irq_enable;        // tx_empty_irq_enable
  logic rx_irq_enable;        // rx_irq_enable
  logic tx_enable;  // transmitter on
  logic rx_enable;  // receiver on
  logic external_clock_select; // clock from the pin
  logic clock_output_enable;   // clock driven onto the pin
  logic sync_mode;  // clocked serial format
  logic parity_en;  // parity checked on receive

  // writes touch only writable bits; reserved bits keep their ones
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `SCS_CTRL_RST;
    end else if (standby_in) begin
      ctrl <= `SCS_CTRL_RST;
    end else if (wr_go && hit_ctrl) begin
      ctrl <= (wbyte & ~`SCS_CTRL_RSVD) | `SCS_CTRL_RSVD;
    end
  end

  // mode bits normally held in the format register
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= `SCS_CFG_RST;
    end else if (standby_in) begin
      cfg <= `SCS_CFG_RST;
    end else if (wr_go && hit_cfg) begin
      cfg <= wbyte;
    end
  end

  assign tx_empty_irq_enable = ctrl[`SCS_TIE_BIT];
  assign rx_irq_enable = ctrl[`SCS_RIE_BIT];
  assign tx_enable = ctrl[`SCS_TE_BIT];
  assign rx_enable = ctrl[`SCS_RE_BIT];
  assign external_clock_select = ctrl[`SCS_EXTERNAL_CLOCK_SELECT_BIT];
  assign clock_output_enable = ctrl[`SCS_CLOCK_OUTPUT_ENABLE_BIT];
  assign sync_mode = cfg[`SCS_CFG_SYNC_BIT];
  assign parity_en = cfg[`SCS_CFG_PAR_BIT];

  // ----------------------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------------------
  logic tx_buffer_empty_flag;  // holding register free
  logic rx_buffer_full_flag;   // holding register has a character
  logic overrun_flag;          // character lost
  logic framing_error_flag;    // stop bit was zero
  logic parity_error_flag;     // parity mismatch
  logic [4:0] armed;           // flag read as one since last write
  logic [4:0] clr_req;         // software clear per flag
  logic te_drop;               // transmitter being switched off
  logic rx_frame_bad;          // completed character has stop error
  logic rx_par_bad;            // completed character fails parity
  logic rx_clean;              // completed character without error

  // a clear needs a prior read of one and a written zero; writing one keeps it
  assign clr_req = {5{wr_go && hit_stat}} & armed & ~wbyte[7:3];
  assign te_drop = wr_go && hit_ctrl && tx_enable && !wbyte[`SCS_TE_BIT];
  assign rx_frame_bad = rx_done_in && !rx_stop_bit_in;
  assign rx_par_bad = rx_done_in && !sync_mode && parity_en && rx_parity_bad_in;
  assign rx_clean = rx_done_in && !rx_frame_bad && !rx_par_bad && !rx_buffer_full_flag;

  // arm on a status read, disarm once any status write lands
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 5'h00;
    end else if (standby_in || (wr_go && hit_stat)) begin
      armed <= 5'h00;
    end else if (rd_go && hit_stat) begin
      armed <= wb_dat_out[7:3]; // what the master actually saw
    end
  end

  // transmit-empty: set beats every clear
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      tx_buffer_empty_flag <= 1'b1;
    end else if (standby_in) begin
      tx_buffer_empty_flag <= 1'b1;
    end else if (tx_load_in || (te_drop && !tx_buffer_empty_flag)) begin
      tx_buffer_empty_flag <= 1'b1;
    end else if (clr_req[4] || ctrl_tx_write_in) begin
      tx_buffer_empty_flag <= 1'b0;
    end
  end

  // receive-full: set only on a clean character
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_buffer_full_flag <= 1'b0;
    end else if (standby_in) begin
      rx_buffer_full_flag <= 1'b0;
    end else if (rx_clean) begin
      rx_buffer_full_flag <= 1'b1;
    end else if (clr_req[3] || ctrl_rx_read_in) begin
      rx_buffer_full_flag <= 1'b0;
    end
  end

  // overrun: a new character while the last is still unread
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      overrun_flag <= 1'b0;
    end else if (standby_in) begin
      overrun_flag <= 1'b0;
    end else if (rx_done_in && rx_buffer_full_flag) begin
      overrun_flag <= 1'b1;
    end else if (clr_req[2]) begin
      overrun_flag <= 1'b0;
    end
  end

  // framing error
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      framing_error_flag <= 1'b0;
    end else if (standby_in) begin
      framing_error_flag <= 1'b0;
    end else if (rx_frame_bad) begin
      framing_error_flag <= 1'b1;
    end else if (clr_req[1]) begin
      framing_error_flag <= 1'b0;
    end
  end

  // parity error; meaningless in sync mode so never set there
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      parity_error_flag <= 1'b0;
    end else if (standby_in) begin
      parity_error_flag <= 1'b0;
    end else if (rx_par_bad) begin
      parity_error_flag <= 1'b1;
    end else if (clr_req[0]) begin
      parity_error_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // interrupt requests
  // ----------------------------------------------------------------------------
  logic any_error; // any receive error flag up

  assign any_error = overrun_flag || framing_error_flag || parity_error_flag;
  assign tx_empty_request_out = tx_empty_irq_enable && tx_buffer_empty_flag;
  assign rx_full_request_out = rx_irq_enable && rx_buffer_full_flag;
  assign rx_error_request_out = rx_irq_enable && any_error;

  // ----------------------------------------------------------------------------
  // sticky interrupt status and mask
  // ----------------------------------------------------------------------------
  logic [`SCS_IRQ_W-1:0] irq_stat; // sticky events
  logic [`SCS_IRQ_W-1:0] irq_mask; // one lets an event reach irq_out
  logic [`SCS_IRQ_W-1:0] irq_prev; // requests one cycle ago
  logic [`SCS_IRQ_W-1:0] irq_now;  // requests this cycle
  logic [`SCS_IRQ_W-1:0] irq_rise; // new request edges

  assign irq_now = {rx_error_request_out, rx_full_request_out, tx_empty_request_out};
  assign irq_rise = irq_now & ~irq_prev;

  // edge detect so a long request marks one event, not a stream
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_prev <= `SCS_IRQ_RST;
    end else begin
      irq_prev <= irq_now;
    end
  end

  // read clears only the bits the master saw; a new edge wins
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= `SCS_IRQ_RST;
    end else if (rd_go && hit_istat) begin
      irq_stat <= (irq_stat & ~wb_dat_out[`SCS_IRQ_W-1:0]) | irq_rise;
    end else begin
      irq_stat <= irq_stat | irq_rise;
    end
  end

  // mask register
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= `SCS_IRQ_RST;
    end else if (wr_go && hit_imask) begin
      irq_mask <= wbyte[`SCS_IRQ_W-1:0];
    end
  end

  assign irq_out = |(irq_stat & irq_mask);

  // ----------------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------------
  scs_byte_t stat_view; // status as seen by software
  scs_byte_t next_rdata; // byte selected by address

  assign stat_view = {tx_buffer_empty_flag, rx_buffer_full_flag, overrun_flag,
                      framing_error_flag, parity_error_flag, 3'h0} | `SCS_STAT_RSVD;

  // unmapped addresses still answer, with zero
  always_comb begin
    next_rdata = 8'h00;
    if (hit_ctrl) begin
      next_rdata = ctrl | `SCS_CTRL_RSVD;
    end else if (hit_stat) begin
      next_rdata = stat_view;
    end else if (hit_cfg) begin
      next_rdata = cfg;
    end else if (hit_istat) begin
      next_rdata = {5'h00, irq_stat};
    end else if (hit_imask) begin
      next_rdata = {5'h00, irq_mask};
    end
  end

  // captured as the request is taken, held through the ack cycle
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (bus_req) begin
      wb_dat_out <= {24'h00_0000, next_rdata};
    end
  end

  // ----------------------------------------------------------------------------
  // pin ownership
  // ----------------------------------------------------------------------------
  logic sck_drive; // clock pin driven by this block

  // sck driven only in sync mode on the internal clock
  assign sck_drive = sync_mode && !external_clock_select && clock_output_enable;

  // transmit pin follows tx_serial_in while the transmitter owns it; held high (mark) when released
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      txd_out <= 1'b1;
      txd_oe_out <= 1'b0;
    end else begin
      txd_out <= tx_enable ? tx_serial_in : 1'b1;
      txd_oe_out <= tx_enable;
    end
  end

  // clock pin: output only when allowed, otherwise released
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      sck_out <= 1'b0;
      sck_oe_out <= 1'b0;
    end else begin
      sck_out <= sck_drive ? int_sck_in : 1'b0;
      sck_oe_out <= sck_drive;
    end
  end

  // receive pin goes to the receiver only while it is enabled; idle high
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_out <= 1'b1;
    end else begin
      rx_data_out <= rx_enable ? rxd_sync : 1'b1;
    end
  end

  // external clock edges; the pin is never driven in this mode
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev <= 1'b0;
      ext_clk_rise_out <= 1'b0;
    end else begin
      sck_prev <= sck_sync;
      ext_clk_rise_out <= external_clock_select && sck_sync && !sck_prev;
    end
  end
endmodule

//--- verif/scs_link_partner.sv
`timescale 1ns/1ps
// ----------------------------------------
// far-side serial device on receive and clock pins
// ----------------------------------------
module scs_link_partner (
  input wire logic run_in,
  input wire logic bit_in,
  output logic rxd_out,
  output logic sck_out
);
  // clock runs only inside a frame and rests low between frames,
  // so no stray edge reaches the block while the link is idle
  initial begin
    sck_out = 1'b0;
    #3;
    forever begin
      #40;
      sck_out <= run_in & ~sck_out;
    end
  end
  // data line follows the commanded bit; idle level is high
  assign rxd_out = bit_in;
endmodule

//--- verif/scs_top_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// port-level checks of the serial control block
// ----------------------------------------
module scs_top_sva (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic wb_stb_in,
  input wire logic wb_ack_out,
  input wire logic [31:0] wb_dat_out,
  input wire logic standby_in,
  input wire logic tx_load_in,
  input wire logic ctrl_tx_write_in,
  input wire logic ctrl_rx_read_in,
  input wire logic rx_done_in,
  input wire logic sck_in,
  input wire logic txd_out,
  input wire logic txd_oe_out,
  input wire logic sck_out,
  input wire logic sck_oe_out,
  input wire logic ext_clk_rise_out,
  input wire logic tx_empty_request_out,
  input wire logic rx_full_request_out,
  input wire logic rx_error_request_out
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  ack_follows_a: assert property ($rose(wb_stb_in) |=> wb_ack_out)
    else $error("bus request not answered one cycle after it was taken");
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out && $stable(wb_dat_out))
    else $error("acknowledge too long or read data moved");
  txd_idle_a: assert property (!txd_oe_out |-> txd_out)
    else $error("transmit pin not high while released");
  sck_idle_a: assert property (!sck_oe_out |-> !sck_out)
    else $error("clock output not low while released");
  // the window allows one cycle either way around the three-flop latency
  clk_pulse_a: assert property (ext_clk_rise_out |-> ($past(sck_in, 2) && !$past(sck_in, 5)) ##1 !ext_clk_rise_out)
    else $error("clock edge pulse without a pin rise");
  standby_quiet_a: assert property (standby_in |=> !tx_empty_request_out && !rx_full_request_out && !rx_error_request_out)
    else $error("request left active after standby");
  rx_read_clear_a: assert property (ctrl_rx_read_in && !rx_done_in |=> !rx_full_request_out)
    else $error("receive request kept after controller read");
  tx_write_clear_a: assert property (ctrl_tx_write_in && !tx_load_in && !wb_ack_out |=> !tx_empty_request_out)
    else $error("transmit request kept after controller write");
endmodule

bind scs_top scs_top_sva chk_i (.*);

//--- verif/tb.sv
`timescale 1ns/1ps
`include "scs_defs.svh"
module tb;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  localparam logic [15:0] a_ct = `SCS_CTRL_IDX;
  localparam logic [15:0] a_st = `SCS_STAT_IDX;
  localparam logic [15:0] a_cf = `SCS_CFG_IDX;
  localparam logic [15:0] a_is = `SCS_IRQ_STAT_IDX;
  localparam logic [15:0] a_im = `SCS_IRQ_MASK_IDX;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
  logic [`SCS_ADDR_W-1:0] wb_adr_in = '0;
  logic [3:0] wb_sel_in = 4'h1; // registers live in the low lane only
  logic [31:0] wb_dat_in = 32'h0;
  logic [31:0] wb_dat_out;
  logic wb_ack_out, txd_out, txd_oe_out, sck_out, sck_oe_out, rx_data_out, ext_clk_rise_out;
  logic tx_empty_request_out, rx_full_request_out, rx_error_request_out, irq_out, rxd_in, sck_in;
  logic [8:0] ev = 9'h0; // event pulses and pin levels, mapped at the instance
  logic p_run = 1'b0, p_bit = 1'b1;
  logic [7:0] rdat, nrise = 8'h0;
  int fails = 0, num_checks = 0;
  wire [7:0] pins = {irq_out, tx_empty_request_out, rx_full_request_out, rx_error_request_out,
    txd_oe_out, txd_out, sck_oe_out, sck_out};
  scs_top uut (.*, .standby_in(ev[0]), .tx_load_in(ev[1]), .ctrl_tx_write_in(ev[2]), .ctrl_rx_read_in(ev[3]),
    .rx_done_in(ev[4]), .rx_stop_bit_in(ev[5]), .rx_parity_bad_in(ev[6]), .tx_serial_in(ev[7]), .int_sck_in(ev[8]));
  scs_link_partner peer (.run_in(p_run), .bit_in(p_bit), .rxd_out(rxd_in), .sck_out(sck_in));
  always #5 clock_in = ~clock_in;
  // count external clock edge pulses seen by the block
  always @(posedge clock_in) if (ext_clk_rise_out === 1'b1) nrise <= nrise + 8'h01;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [15:0] i, input logic [7:0] d);
    {wb_cyc_in, wb_stb_in, wb_we_in} <= {2'h3, w};
    wb_adr_in <= {i, 2'h0};
    wb_dat_in <= {24'h0, d};
    // no cycle count assumed; only the watchdog ends a wait that never ends
    do begin
      @(posedge clock_in);
    end while (wb_ack_out !== 1'b1);
    rdat = wb_dat_out[7:0];
    {wb_cyc_in, wb_stb_in} <= 2'h0;
    @(posedge clock_in);
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h0);
    chk(rdat, e);
  endtask
  // pin outputs are registered, so let them settle before looking
  task automatic pk(input logic [7:0] e);
    repeat (3) @(posedge clock_in);
    chk(pins, e);
  endtask
  task automatic pulse(input logic [8:0] m);
    ev <= m;
    @(posedge clock_in);
    ev <= 9'h0;
    @(posedge clock_in);
  endtask
  task automatic give_verdict;
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(a_ct, 8'h0C);
    rd(a_st, 8'h87);
    rd(16'h0000, 8'h00);
    wr(a_ct, 8'hF3);
    rd(a_ct, 8'hFF);
    wr(a_ct, 8'h00);
    rd(a_ct, 8'h0C);
  endtask
  task automatic t_tx;
    wr(a_ct, 8'h80);
    pk(8'h44);
    pulse(9'h004);
    pk(8'h04);
    rd(a_st, 8'h07);
    pulse(9'h002);
    rd(a_st, 8'h87);
    wr(a_st, 8'hFF);
    rd(a_st, 8'h87);
    wr(a_st, 8'h00);
    rd(a_st, 8'h07);
    wr(a_ct, 8'hA0);
    pk(8'h08);
    wr(a_ct, 8'h80);
    pk(8'h44);
    wr(a_ct, 8'h00);
  endtask
  task automatic t_rx;
    wr(a_ct, 8'h40);
    pulse(9'h030);
    pk(8'h24);
    pulse(9'h030);
    pk(8'h34);
    rd(a_st, 8'hE7);
    pulse(9'h008);
    pk(8'h14);
    pulse(9'h010);
    wr(a_cf, 8'h02);
    pulse(9'h070);
    rd(a_st, 8'hBF);
    wr(a_ct, 8'h00);
    pk(8'h04);
    wr(a_ct, 8'h40);
    pk(8'h14);
    wr(a_st, 8'h00);
    pk(8'h04);
    rd(a_st, 8'h07);
    pulse(9'h002);
    wr(a_cf, 8'h03);
    pulse(9'h070);
    rd(a_st, 8'hC7);
    pulse(9'h008);
    wr(a_cf, 8'h00);
  endtask
  task automatic t_link;
    p_bit <= 1'b0;
    wr(a_ct, 8'h10);
    pk(8'h04);
    chk({7'h0, rx_data_out}, 8'h00);
    wr(a_ct, 8'h20);
    ev <= 9'h080;
    pk(8'h0C);
    chk({7'h0, rx_data_out}, 8'h01);
    p_bit <= 1'b1;
    wr(a_cf, 8'h01);
    ev <= 9'h100;
    wr(a_ct, 8'h01);
    pk(8'h07);
    wr(a_cf, 8'h00);
    pk(8'h04);
    wr(a_cf, 8'h01);
    wr(a_ct, 8'h03);
    pk(8'h04);
    ev <= 9'h000;
    p_run <= 1'b1;
    repeat (80) @(posedge clock_in);
    p_run <= 1'b0;
    repeat (10) @(posedge clock_in);
    chk(nrise, 8'h0A);
    wr(a_ct, 8'h00);
    wr(a_cf, 8'h00);
  endtask
  task automatic t_irq;
    rd(a_is, 8'h07);
    wr(a_im, 8'h01);
    wr(a_ct, 8'h80);
    pk(8'hC4);
    rd(a_is, 8'h01);
    pk(8'h44);
    wr(a_im, 8'h00);
    wr(a_ct, 8'h00);
    wr(a_ct, 8'h80);
    pk(8'h44);
    rd(a_is, 8'h01);
  endtask
  task automatic t_standby;
    wr(a_ct, 8'hF3);
    pulse(9'h030);
    pulse(9'h001);
    rd(a_ct, 8'h0C);
    rd(a_st, 8'h87);
    pk(8'h04);
  endtask
  initial begin
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    t_regs();
    t_tx();
    t_rx();
    t_link();
    t_irq();
    t_standby();
    give_verdict();
  end
  // the whole run needs about 3 us; over fifteen times that means a hang
  initial begin
    #50000;
    chk(8'h00, 8'h01); // watchdog expired: reported and counted as a mismatch
    give_verdict();
  end
endmodule
